// ==== rtl/cpu_special_regs_pkg.sv ====
// Constants, layouts and types of the processor special register bank
package cpu_special_regs_pkg;
    // Register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_GUARD = 8'h04;
    localparam logic [7:0] IDX_EXT = 8'h0b;
    localparam logic [7:0] IDX_SP_LOW = 8'h0d;
    localparam logic [7:0] IDX_SP_HIGH = 8'h0e;
    localparam logic [7:0] IDX_FLAGS = 8'h0f;
    localparam int ADDR_W = 12;
    localparam int IDX_LSB = 2;

    // Guard keys
    localparam logic [7:0] SELF_PROGRAM_KEY = 8'h9d;
    localparam logic [7:0] IO_UNLOCK_KEY = 8'hd8;
    // Instructions that a key or a stack pointer low write covers
    localparam logic [2:0] WINDOW_INSTRS = 3'h4;
    localparam logic [2:0] CNT_ZERO = 3'h0;
    localparam logic [2:0] CNT_ONE = 3'h1;

    // Reset values; stack pointer starts at the top of an 8 KB SRAM at 0x6000
    localparam logic [7:0] GUARD_RESET = 8'h00;
    localparam logic [7:0] EXT_RESET = 8'h00;
    localparam logic [15:0] SP_RESET = 16'h7fff;
    localparam logic [15:0] SP_MASK = 16'h7fff;
    localparam logic [7:0] EXT_MASK = 8'h01;

    // Flags register bit positions
    localparam int FLG_IE = 7;
    localparam int FLG_T = 6;
    localparam int FLG_H = 5;
    localparam int FLG_S = 4;
    localparam int FLG_V = 3;
    localparam int FLG_N = 2;
    localparam int FLG_Z = 1;
    localparam int FLG_C = 0;
    // Arithmetic update mask/value bit positions: H V N Z C
    localparam int ALU_H = 4;
    localparam int ALU_V = 3;
    localparam int ALU_N = 2;
    localparam int ALU_Z = 1;
    localparam int ALU_C = 0;

    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // Guard window mode; codes equal the read-back bits
    typedef enum logic [1:0] {
        WIN_NONE = 2'b00,
        WIN_IO = 2'b01,
        WIN_SPM = 2'b10
    } window_mode_t;
endpackage : cpu_special_regs_pkg

// ==== rtl/cpu_special_regs.sv ====
// Processor special register bank: guard, stack pointer, flags, pointer extension
// Function
// R1: Valid key opens protected access for the next four executed instructions.
// R2: No interrupt service while the guard window is open; resume afterwards.
// R3: Guard bit 0 reads one while the I/O unlock window is open.
// R4: Guard bit 1 reads one while the self-programming window is open.
// R5: Guard bits 7 to 2 always read zero.
// R6: Key 0x9D enables self-programming, 0xD8 unlocks protected I/O.
// R7: An executed write instruction closes the guard window early.
// R8: Reset loads the stack pointer with the highest SRAM address.
// R9: Stack pointer keeps only implemented bits; the rest read zero.
// R10: Stack pointer low byte at base offset, high byte at base plus one.
// R11: Low byte write blocks interrupts four instructions or until next I/O write.
// R12: Flags bit 7 is the global interrupt enable.
// R13: Interrupt entry and return never change the global enable.
// R14: Enable instruction sets, disable instruction clears the global enable.
// R15: Changing the global enable by register write costs one wait state.
// R16: Flags bit 6 is the bit store target and bit load source.
// R17: Flags bit 5 follows half carry of supporting arithmetic.
// R18: Flags bit 4 always equals negative XOR overflow.
// R19: Flags bit 3 follows two's complement overflow.
// R20: Flags bits 2, 1, 0 follow negative, zero and carry results.
// R21: Extension byte prefixes the third index pointer for far program accesses.
// R22: Extension byte is the address top byte; unimplemented bits read zero.
//
// Our own choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module cpu_special_regs (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cpu_special_regs_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Execution side
    input wire logic instr_done,
    input wire logic write_instr_done,
    input wire logic io_write,
    input wire logic irq_on_instr,
    input wire logic irq_off_instr,
    input wire logic bit_store_instr,
    input wire logic bit_store_val,
    input wire logic [4:0] alu_flag_mask,
    input wire logic [4:0] alu_flag_val,
    input wire logic sp_we,
    input wire logic [15:0] sp_wval,
    input wire logic far_access,
    input wire logic [15:0] z_pointer,
    // State towards the core
    output logic io_unlock_active,
    output logic self_prog_active,
    output logic irq_allowed,
    output logic bit_load_val,
    output logic [7:0] flags_out,
    output logic [15:0] stack_pointer,
    output logic [7:0] upper_pointer_extension,
    output logic [23:0] far_address
);
    import cpu_special_regs_pkg::*;

    typedef struct packed {
        window_mode_t mode;
        logic [2:0] guard_cnt;
        logic [2:0] hold_cnt;
        logic ie;
        logic t;
        logic h;
        logic sgn;
        logic v;
        logic n;
        logic z;
        logic c;
        logic [15:0] sp;
        logic [7:0] ext;
        logic [23:0] far_addr;
        logic irq_ok;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic waited;
    } state_t;

    state_t st_q;
    state_t st_d;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a[ADDR_W-1:IDX_LSB] == {{(ADDR_W-IDX_LSB-$bits(idx)){1'b0}}, idx})
            && (a[IDX_LSB-1:0] == '0);
    endfunction : hit

    function automatic logic [7:0] flags_of(input state_t s);
        flags_of = {s.ie, s.t, s.h, s.sgn, s.v, s.n, s.z, s.c};
    endfunction : flags_of

    logic setup;
    logic done;
    logic wr_done;
    logic mapped;
    logic guard_wr;
    logic key_io;
    logic key_spm;
    logic spl_wr;
    logic sph_wr;
    logic flags_wr;
    logic ext_wr;
    logic ie_change;

    always_comb begin
        setup = psel && !penable;
        done = psel && penable && st_q.ready;
        wr_done = done && pwrite;
        mapped = hit(paddr, IDX_GUARD) || hit(paddr, IDX_EXT) || hit(paddr, IDX_SP_LOW)
            || hit(paddr, IDX_SP_HIGH) || hit(paddr, IDX_FLAGS);
        guard_wr = wr_done && hit(paddr, IDX_GUARD);
        key_io = guard_wr && (pwdata[7:0] == IO_UNLOCK_KEY);
        key_spm = guard_wr && (pwdata[7:0] == SELF_PROGRAM_KEY);
        spl_wr = wr_done && hit(paddr, IDX_SP_LOW);
        sph_wr = wr_done && hit(paddr, IDX_SP_HIGH);
        flags_wr = wr_done && hit(paddr, IDX_FLAGS);
        ext_wr = wr_done && hit(paddr, IDX_EXT);
        ie_change = pwrite && hit(paddr, IDX_FLAGS) && (pwdata[FLG_IE] != st_q.ie);
    end

    always_comb begin
        st_d = st_q;

        // Guard window; a fresh key wins over a closing event in the same cycle
        if (key_io) begin
            st_d.mode = WIN_IO; // R6 R3
            st_d.guard_cnt = WINDOW_INSTRS; // R1
        end else if (key_spm) begin
            st_d.mode = WIN_SPM; // R6 R4
            st_d.guard_cnt = WINDOW_INSTRS; // R1
        end else if (st_q.mode != WIN_NONE) begin
            if (write_instr_done) begin
                st_d.mode = WIN_NONE; // R7
                st_d.guard_cnt = CNT_ZERO;
            end else if (instr_done) begin
                st_d.guard_cnt = st_q.guard_cnt - CNT_ONE; // R1
                if (st_q.guard_cnt == CNT_ONE) begin
                    st_d.mode = WIN_NONE;
                end
            end
        end

        // Interrupt hold after a low byte write
        if (spl_wr) begin
            st_d.hold_cnt = WINDOW_INSTRS; // R11
        end else if (wr_done || io_write) begin
            st_d.hold_cnt = CNT_ZERO; // R11
        end else if (instr_done && st_q.hold_cnt != CNT_ZERO) begin
            st_d.hold_cnt = st_q.hold_cnt - CNT_ONE; // R11
        end

        // Stack pointer: bus bytes, then core loads
        if (spl_wr) begin
            st_d.sp[7:0] = pwdata[7:0] & SP_MASK[7:0]; // R10 R9
        end
        if (sph_wr) begin
            st_d.sp[15:8] = pwdata[7:0] & SP_MASK[15:8]; // R10 R9
        end
        if (sp_we) begin
            st_d.sp = sp_wval & SP_MASK; // R9
        end

        if (ext_wr) begin
            st_d.ext = pwdata[7:0] & EXT_MASK; // R22
        end

        // Flags: bus write first, instruction effects override it
        if (flags_wr) begin
            st_d.ie = pwdata[FLG_IE]; // R12
            st_d.t = pwdata[FLG_T];
            st_d.h = pwdata[FLG_H];
            st_d.v = pwdata[FLG_V];
            st_d.n = pwdata[FLG_N];
            st_d.z = pwdata[FLG_Z];
            st_d.c = pwdata[FLG_C];
        end
        // Interrupt entry and return have no path to the enable bit
        if (irq_on_instr) begin
            st_d.ie = 1'b1; // R14 R13
        end else if (irq_off_instr) begin
            st_d.ie = 1'b0; // R14
        end
        if (bit_store_instr) begin
            st_d.t = bit_store_val; // R16
        end
        if (alu_flag_mask[ALU_H]) begin
            st_d.h = alu_flag_val[ALU_H]; // R17
        end
        if (alu_flag_mask[ALU_V]) begin
            st_d.v = alu_flag_val[ALU_V]; // R19
        end
        if (alu_flag_mask[ALU_N]) begin
            st_d.n = alu_flag_val[ALU_N]; // R20
        end
        if (alu_flag_mask[ALU_Z]) begin
            st_d.z = alu_flag_val[ALU_Z]; // R20
        end
        if (alu_flag_mask[ALU_C]) begin
            st_d.c = alu_flag_val[ALU_C]; // R20
        end

        // Sign kept in a flop so the flags output has no gate after the register
        st_d.sgn = st_d.n ^ st_d.v; // R18

        // Far address uses the extension byte as it stood before this cycle
        if (far_access) begin
            st_d.far_addr = {st_q.ext, z_pointer}; // R21
        end

        // Registered so the core sees a glitch-free permission
        st_d.irq_ok = st_d.ie && (st_d.mode == WIN_NONE) // R12 R2
            && (st_d.hold_cnt == CNT_ZERO); // R11

        // Bus answer: one access cycle, two when the write flips the enable
        if (setup) begin
            st_d.ready = !ie_change; // R15
            st_d.waited = ie_change;
            st_d.err = !mapped;
        end else if (st_q.waited) begin
            st_d.ready = 1'b1; // R15
            st_d.waited = 1'b0;
        end else if (done) begin
            st_d.ready = 1'b0;
            st_d.err = 1'b0;
        end

        // Read data tracks the address every cycle; sampled by the master one edge later
        if (hit(paddr, IDX_GUARD)) begin
            st_d.rdata = {30'h0000_0000, st_q.mode}; // R3 R4 R5
        end else if (hit(paddr, IDX_EXT)) begin
            st_d.rdata = {24'h00_0000, st_q.ext}; // R22
        end else if (hit(paddr, IDX_SP_LOW)) begin
            st_d.rdata = {24'h00_0000, st_q.sp[7:0]}; // R10
        end else if (hit(paddr, IDX_SP_HIGH)) begin
            st_d.rdata = {24'h00_0000, st_q.sp[15:8]}; // R10
        end else if (hit(paddr, IDX_FLAGS)) begin
            st_d.rdata = {24'h00_0000, flags_of(st_q)}; // R18
        end else begin
            st_d.rdata = RDATA_ZERO;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q.mode <= WIN_NONE;
            st_q.guard_cnt <= CNT_ZERO;
            st_q.hold_cnt <= CNT_ZERO;
            st_q.ie <= 1'b0;
            st_q.t <= 1'b0;
            st_q.h <= 1'b0;
            st_q.sgn <= 1'b0;
            st_q.v <= 1'b0;
            st_q.n <= 1'b0;
            st_q.z <= 1'b0;
            st_q.c <= 1'b0;
            st_q.sp <= SP_RESET; // R8
            st_q.ext <= EXT_RESET;
            st_q.far_addr <= '0;
            st_q.irq_ok <= 1'b0;
            st_q.rdata <= RDATA_ZERO;
            st_q.ready <= 1'b0;
            st_q.err <= 1'b0;
            st_q.waited <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.rdata;
    assign pready = st_q.ready;
    assign pslverr = st_q.err;
    assign io_unlock_active = st_q.mode[0];
    assign self_prog_active = st_q.mode[1];
    assign irq_allowed = st_q.irq_ok;
    assign bit_load_val = st_q.t; // R16
    assign flags_out = flags_of(st_q);
    assign stack_pointer = st_q.sp;
    assign upper_pointer_extension = st_q.ext;
    assign far_address = st_q.far_addr;

    AST_KEY_OPENS_IO: assert property ( // R6
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && key_io |=> io_unlock_active && !self_prog_active
    ) else $error("I/O unlock key did not open the I/O window");

    AST_KEY_OPENS_SPM: assert property ( // R6
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && key_spm |=> self_prog_active && !io_unlock_active
    ) else $error("Self-programming key did not open its window");

    AST_GUARD_HIGH_ZERO: assert property ( // R5
        @(posedge sys_clk) disable iff (!reset_n)
        done && !pwrite && hit(paddr, IDX_GUARD) |-> prdata[7:2] == 6'h00
    ) else $error("Guard upper bits read non-zero");

    AST_WINDOW_NO_IRQ: assert property ( // R2
        @(posedge sys_clk) disable iff (!reset_n)
        (io_unlock_active || self_prog_active) |-> !irq_allowed
    ) else $error("Interrupts allowed inside guard window");

    AST_FOURTH_CLOSES: assert property ( // R1
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && st_q.mode != WIN_NONE && st_q.guard_cnt == CNT_ONE && instr_done && !guard_wr
        |=> !io_unlock_active && !self_prog_active
    ) else $error("Guard window outlived four instructions");

    AST_FOUR_INSTR_OPEN: assert property ( // R1
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && (io_unlock_active || self_prog_active) && st_q.guard_cnt != CNT_ONE
        && !write_instr_done |=> io_unlock_active || self_prog_active
    ) else $error("Guard window closed before four instructions");

    AST_WRITE_CLOSES: assert property ( // R7
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && st_q.mode != WIN_NONE && write_instr_done && !guard_wr
        |=> !io_unlock_active && !self_prog_active
    ) else $error("Write instruction did not close guard window");

    AST_SPL_HOLD: assert property ( // R11
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && spl_wr |=> !irq_allowed
    ) else $error("Interrupts allowed right after stack low write");

    AST_SP_UNUSED_ZERO: assert property ( // R9
        @(posedge sys_clk) disable iff (!reset_n)
        (stack_pointer & ~SP_MASK) == 16'h0000
    ) else $error("Unimplemented stack pointer bits set");

    AST_SIGN_XOR: assert property ( // R18
        @(posedge sys_clk) disable iff (!reset_n)
        flags_out[FLG_S] == (flags_out[FLG_N] ^ flags_out[FLG_V])
    ) else $error("Sign flag differs from N xor V");

    AST_IE_WAIT: assert property ( // R15
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && setup && ie_change ##1 clk_en ##1 clk_en |-> !$past(pready) && pready
    ) else $error("Enable change did not insert one wait state");

    AST_IRQ_ON: assert property ( // R14
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && irq_on_instr |=> flags_out[FLG_IE]
    ) else $error("Enable instruction did not set global enable");

    AST_IE_GATES_IRQ: assert property ( // R12
        @(posedge sys_clk) disable iff (!reset_n)
        !flags_out[FLG_IE] |-> !irq_allowed
    ) else $error("Interrupts allowed with global enable clear");

    AST_FAR_ADDR: assert property ( // R21
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && far_access |=> far_address == {$past(st_q.ext), $past(z_pointer)}
    ) else $error("Far address not formed from extension and pointer");

    AST_GUARD_READBACK: assert property ( // R3 R4
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && hit(paddr, IDX_GUARD) |=> prdata[1:0] == {$past(self_prog_active), $past(io_unlock_active)}
    ) else $error("Guard read-back bits differ from window state");

    AST_IRQ_OFF: assert property ( // R14
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && irq_off_instr && !irq_on_instr |=> !flags_out[FLG_IE]
    ) else $error("Disable instruction did not clear global enable");

    AST_READY_PULSE: assert property ( // R15
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && pready |=> !pready
    ) else $error("Bus ready stood for more than one cycle");

    AST_IO_WRITE_ENDS_HOLD: assert property ( // R11
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && io_write && !spl_wr |=> st_q.hold_cnt == CNT_ZERO
    ) else $error("I/O write did not end the stack interrupt hold");
endmodule : cpu_special_regs
`default_nettype wire

// ==== test/core_exec_model.sv ====
// Behavioural execution side that strobes the special register bank
`timescale 1ns/100ps
`default_nettype none
module core_exec_model (
    input wire logic sys_clk,
    output logic instr_done,
    output logic write_instr_done,
    output logic io_write,
    output logic irq_on_instr,
    output logic irq_off_instr,
    output logic bit_store_instr,
    output logic bit_store_val,
    output logic [4:0] alu_flag_mask,
    output logic [4:0] alu_flag_val,
    output logic sp_we,
    output logic [15:0] sp_wval,
    output logic far_access,
    output logic [15:0] z_pointer
);
    initial begin
        {instr_done, write_instr_done, io_write, irq_on_instr, irq_off_instr} = 5'h00;
        {bit_store_instr, bit_store_val, sp_we, far_access} = 4'h0;
        {alu_flag_mask, alu_flag_val} = 10'h000;
        {sp_wval, z_pointer} = 32'h0000_0000;
    end

    // Select bits of k: instr, write, io, on, off, store, alu, sp, far
    task automatic op(input logic [8:0] k, input logic [15:0] v);
        @(posedge sys_clk);
        instr_done <= k[0];
        write_instr_done <= k[1];
        io_write <= k[2];
        irq_on_instr <= k[3];
        irq_off_instr <= k[4];
        bit_store_instr <= k[5];
        bit_store_val <= v[0];
        alu_flag_mask <= k[6] ? v[4:0] : 5'h00;
        alu_flag_val <= v[9:5];
        sp_we <= k[7];
        sp_wval <= v;
        far_access <= k[8];
        z_pointer <= v;
        @(posedge sys_clk);
        {instr_done, write_instr_done, io_write, irq_on_instr, irq_off_instr} <= 5'h00;
        {bit_store_instr, sp_we, far_access, alu_flag_mask} <= 8'h00;
        // Released data lines flip so stale values never look valid
        bit_store_val <= ~v[0];
        alu_flag_val <= ~v[9:5];
        sp_wval <= ~v;
        z_pointer <= ~v;
    endtask : op
endmodule : core_exec_model
`default_nettype wire

// ==== test/cpu_special_register_bank_tb.sv ====
// Self-checking bench for the special register bank
`timescale 1ns/100ps
`default_nettype none
module cpu_special_register_bank_tb;
    import cpu_special_regs_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, instr_done, write_instr_done, io_write;
    logic irq_on_instr, irq_off_instr, bit_store_instr, bit_store_val, sp_we, far_access;
    logic [4:0] alu_flag_mask, alu_flag_val;
    logic [15:0] sp_wval, z_pointer, stack_pointer, sp_m;
    logic io_unlock_active, self_prog_active, irq_allowed, bit_load_val;
    logic [7:0] flags_out, upper_pointer_extension, ext_m;
    logic [23:0] far_address;
    logic clk_en = 1'b1;
    logic [7:0] flg = 8'h00;
    logic [31:0] seed = 32'he680;
    int n_fail = 0;
    int comparisons = 0;

    always #2.5 sys_clk = ~sys_clk;

    cpu_special_regs DUT (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_done(instr_done),
        .write_instr_done(write_instr_done), .io_write(io_write),
        .irq_on_instr(irq_on_instr), .irq_off_instr(irq_off_instr),
        .bit_store_instr(bit_store_instr), .bit_store_val(bit_store_val),
        .alu_flag_mask(alu_flag_mask), .alu_flag_val(alu_flag_val), .sp_we(sp_we),
        .sp_wval(sp_wval), .far_access(far_access), .z_pointer(z_pointer),
        .io_unlock_active(io_unlock_active), .self_prog_active(self_prog_active),
        .irq_allowed(irq_allowed), .bit_load_val(bit_load_val), .flags_out(flags_out),
        .stack_pointer(stack_pointer), .upper_pointer_extension(upper_pointer_extension),
        .far_address(far_address));

    core_exec_model core (.sys_clk(sys_clk), .instr_done(instr_done),
        .write_instr_done(write_instr_done), .io_write(io_write),
        .irq_on_instr(irq_on_instr), .irq_off_instr(irq_off_instr),
        .bit_store_instr(bit_store_instr), .bit_store_val(bit_store_val),
        .alu_flag_mask(alu_flag_mask), .alu_flag_val(alu_flag_val), .sp_we(sp_we),
        .sp_wval(sp_wval), .far_access(far_access), .z_pointer(z_pointer));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk_rd(input logic [32:0] got, input logic [32:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk_rd

    task automatic chk_pin(input logic [23:0] got, input logic [23:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk_pin

    // Request held until pready is sampled high, then released
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                       output logic [32:0] r, output int n);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {seed[31:8], d};
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1);
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input int cyc);
        logic [32:0] r;
        int n;
        apb(1'b1, idx, d, r, n);
        chk_rd({r[32], 32'(n)}, {1'b0, 32'(cyc)}, "write wait");
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic err);
        logic [32:0] r;
        int n;
        apb(1'b0, idx, 8'h00, r, n);
        chk_rd(r, {err, 24'h00_0000, e}, "read");
    endtask : rd

    task automatic win(input logic [1:0] g, input logic irq);
        @(posedge sys_clk);
        chk_pin({21'h00_0000, self_prog_active, io_unlock_active, irq_allowed},
            {21'h00_0000, g, irq}, "window");
    endtask : win

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    initial begin : watchdog
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        close_out;
    end

    initial begin : main
        logic [31:0] v;
        sp_m = SP_RESET;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(IDX_GUARD, GUARD_RESET, 1'b0);
        rd(IDX_EXT, EXT_RESET, 1'b0);
        rd(IDX_SP_LOW, SP_RESET[7:0], 1'b0);
        rd(IDX_SP_HIGH, SP_RESET[15:8], 1'b0);
        rd(IDX_FLAGS, 8'h00, 1'b0);
        rd(8'h05, 8'h00, 1'b1);
        wr(IDX_FLAGS, 8'h80, 2);
        wr(IDX_FLAGS, 8'h81, 1);
        flg = 8'h81;
        win(2'b00, 1'b1);
        for (int k = 0; k < 2; k++) begin
            wr(IDX_GUARD, k ? IO_UNLOCK_KEY : SELF_PROGRAM_KEY, 1);
            rd(IDX_GUARD, k ? 8'h01 : 8'h02, 1'b0);
            repeat (3) core.op(9'h001, 16'h0000);
            win(k ? 2'b01 : 2'b10, 1'b0);
            core.op(9'h001, 16'h0000);
            win(2'b00, 1'b1);
        end
        wr(IDX_GUARD, IO_UNLOCK_KEY, 1);
        core.op(9'h003, 16'h0000);
        win(2'b00, 1'b1);
        wr(IDX_GUARD, 8'h55, 1);
        rd(IDX_GUARD, 8'h00, 1'b0);
        // High byte first: any later bus write would end the hold early
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            sp_m = seed[15:0] & SP_MASK;
            wr(IDX_SP_HIGH, seed[15:8], 1);
            wr(IDX_SP_LOW, seed[7:0], 1);
            rd(IDX_SP_HIGH, sp_m[15:8], 1'b0);
            rd(IDX_SP_LOW, sp_m[7:0], 1'b0);
            win(2'b00, 1'b0);
            repeat (i + 2) core.op(9'h001, 16'h0000);
            win(2'b00, i == 2);
            core.op(9'h004, 16'h0000);
            win(2'b00, 1'b1);
        end
        core.op(9'h080, 16'hffff);
        @(posedge sys_clk);
        chk_pin({8'h00, stack_pointer}, {8'h00, 16'hffff & SP_MASK}, "stack");
        // Mid-run reset must bring the stack pointer and flags back
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        flg = 8'h00;
        rd(IDX_SP_LOW, SP_RESET[7:0], 1'b0);
        rd(IDX_SP_HIGH, SP_RESET[15:8], 1'b0);
        rd(IDX_FLAGS, 8'h00, 1'b0);
        for (int i = 0; i < 32; i++) begin
            seed = lfsr(seed);
            v = seed;
            case (v[18:16])
                3'h1: core.op(9'h008, 16'h0000);
                3'h2: core.op(9'h010, 16'h0000);
                3'h3: core.op(9'h018, 16'h0000);
                3'h4: core.op(9'h020, v[15:0]);
                3'h5: wr(IDX_FLAGS, v[7:0], (v[7] != flg[7]) ? 2 : 1);
                default: core.op(9'h040, v[15:0]);
            endcase
            case (v[18:16])
                3'h1, 3'h3: flg[7] = 1'b1;
                3'h2: flg[7] = 1'b0;
                3'h4: flg[6] = v[0];
                3'h5: flg = v[7:0] & 8'hef;
                default: for (int b = 0; b < 5; b++) begin
                    if (v[b]) flg[b == 4 ? 5 : b] = v[b + 5];
                end
            endcase
            @(posedge sys_clk);
            chk_pin({14'h0000, flags_out, bit_load_val, irq_allowed},
                {14'h0000, flg[7:5], flg[3] ^ flg[2], flg[3:0], flg[6], flg[7]}, "flags");
        end
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            ext_m = seed[7:0] & EXT_MASK;
            wr(IDX_EXT, seed[7:0], 1);
            rd(IDX_EXT, ext_m, 1'b0);
            core.op(9'h100, seed[31:16]);
            @(posedge sys_clk);
            chk_pin(far_address, {ext_m, seed[31:16]}, "far");
        end
        // Enable low: an instruction that would flip the enable must be ignored
        clk_en <= 1'b0;
        core.op(flg[7] ? 9'h010 : 9'h008, 16'h0000);
        @(posedge sys_clk);
        chk_pin({16'h0000, flags_out}, {16'h0000, flg[7:5], flg[3] ^ flg[2], flg[3:0]}, "freeze");
        clk_en <= 1'b1;
        close_out;
    end
endmodule : cpu_special_register_bank_tb
`default_nettype wire
